// ### core/acs_ctrl.sv
/*
  Converter sequencing, power modes, sleep/idle handling, result formatting
  and analog pin qualification. Drives a SAR core and sample-and-hold.
  Assumes the core answers each start with one done pulse and result;
  processor sleep/idle and control inputs are synchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module acs_ctrl (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_converter_on,
  input  wire logic                       i_sample_control_bit,
  input  wire logic                       i_auto_sample,
  input  wire logic                       i_trigger,
  input  wire logic                       i_rc_clock_select,
  input  wire logic                       i_stop_in_idle,
  input  wire logic                       i_cpu_sleep,
  input  wire logic                       i_cpu_idle,
  input  wire logic                       i_int_enable,
  input  wire logic                       i_done_clear,
  input  wire logic [1:0]                 i_output_format_select,
  input  wire logic [3:0]                 i_channel_select,
  input  wire logic [acs_pkg::PINS-1:0]   i_analog_pin_config,
  input  wire logic [acs_pkg::PINS-1:0]   i_pin_level,
  input  wire logic                       i_core_done,
  input  wire logic [acs_pkg::RES_W-1:0]  i_core_result,
  input  wire logic                       i_wr_valid,
  input  wire logic [acs_pkg::BUS_W-1:0]  i_wr_data,
  input  wire logic                       i_rd_ready,
  output logic                            o_wr_ack,
  output logic                            o_rd_valid,
  output logic      [acs_pkg::BUS_W-1:0]  o_rd_data,
  output logic                            o_done,
  output logic                            o_wake,
  output logic                            o_core_power,
  output logic                            o_core_clk_en,
  output logic                            o_core_sample,
  output logic                            o_core_start,
  output logic                            o_discharge,
  output logic                            o_mux_connect,
  output logic      [acs_pkg::PINS-1:0]   o_port_read
);
  import acs_pkg::*;

  typedef struct packed {
    acs_state_t          st;
    logic [3:0]          cnt;
    logic                sampled;
    logic [3:0]          ch;
    logic                sample_control_bit_prev;
    logic                done;
    logic                pwr_dn;
    logic                wake;
    logic                wr_ack;
    logic [PINS-1:0]     pin_s1;
    logic [PINS-1:0]     pin_s2;
    logic [PINS-1:0]     port;
    logic                rdv;
    logic [BUS_W-1:0]    rdd;
    logic                power;
    logic                clk_en;
    logic                sample;
    logic                start;
    logic                discharge;
    logic                mux;
  } acs_ctrl_st_t;

  acs_ctrl_st_t s_ff;
  acs_ctrl_st_t nxt_s;

  logic             halt;
  logic             fifo_wr_valid;
  logic             fifo_wr_ready;
  logic [RES_W-1:0] fifo_wr_data;
  logic             fifo_rd_valid;
  logic             fifo_rd_ready;
  logic [RES_W-1:0] fifo_rd_data;
  logic             core_push;
  logic             sw_push;
  logic             begin_conv;

  function automatic logic [BUS_W-1:0] fmt(input logic [1:0] sel, input logic [RES_W-1:0] d);
    logic [BUS_W-1:0] r;
    r = '0;
    unique case (sel)
      FMT_INT:  r = {{(BUS_W-RES_W){1'b0}}, d};
      FMT_SINT: r = {{(BUS_W-RES_W){d[RES_W-1]}}, d};
      FMT_FRAC: r = {d, {FRAC_SHIFT{1'b0}}};
      FMT_SFRC: r = {d, {FRAC_SHIFT{1'b0}}};
    endcase
    return r;
  endfunction

  // Sleep without RC clock, or idle with stop-in-idle
  assign halt = (i_cpu_sleep && !i_rc_clock_select) || (i_cpu_idle && i_stop_in_idle);

  assign core_push     = (s_ff.st == ST_CONVERT) && i_core_done && !halt && i_converter_on;
  assign sw_push       = i_wr_valid && !core_push;
  assign fifo_wr_valid = core_push || sw_push;
  // Software writes taken right-justified
  assign fifo_wr_data  = core_push ? i_core_result : i_wr_data[RES_W-1:0];
  assign fifo_rd_ready = !s_ff.rdv || i_rd_ready;

  acs_fifo #(
    .WIDTH (RES_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_wr_valid (fifo_wr_valid),
    .o_wr_ready (fifo_wr_ready),
    .i_wr_data  (fifo_wr_data),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (fifo_rd_ready),
    .o_rd_data  (fifo_rd_data)
  );

  always_comb begin
    nxt_s           = s_ff;
    nxt_s.start     = 1'b0;
    nxt_s.discharge = 1'b0;
    nxt_s.wake      = 1'b0;
    nxt_s.wr_ack    = sw_push && fifo_wr_ready;
    nxt_s.sample_control_bit_prev = i_sample_control_bit;
    nxt_s.ch        = i_channel_select;
    begin_conv      = 1'b0;
    // Pin synchronisers; analog pins read as zero
    nxt_s.pin_s1    = i_pin_level;
    nxt_s.pin_s2    = s_ff.pin_s1;
    nxt_s.port      = s_ff.pin_s2 & ~i_analog_pin_config;
    // Channel change restarts the sample
    if (i_channel_select != s_ff.ch) begin
      nxt_s.sampled = 1'b0;
      nxt_s.cnt     = '0;
    end
    unique case (s_ff.st)
      ST_OFF: begin
        if (i_converter_on) begin
          nxt_s.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!s_ff.pwr_dn && !halt && fifo_wr_ready &&
            (i_auto_sample || i_sample_control_bit)) begin
          nxt_s.st        = ST_SAMPLE;
          nxt_s.cnt       = '0;
          nxt_s.sampled   = 1'b0;
          nxt_s.discharge = 1'b1;
        end
      end
      ST_SAMPLE: begin
        if (i_channel_select == s_ff.ch && !s_ff.sampled) begin
          nxt_s.cnt = s_ff.cnt + 4'h1;
          if (s_ff.cnt + 4'h1 >= TAD_CYC) begin
            nxt_s.sampled = 1'b1;
          end
        end
        if (i_auto_sample) begin
          begin_conv = i_trigger && s_ff.sampled;
        end else if (s_ff.sample_control_bit_prev && !i_sample_control_bit) begin
          begin_conv = s_ff.sampled;
          if (!s_ff.sampled) begin
            nxt_s.st = ST_IDLE;
          end
        end
        if (begin_conv) begin
          nxt_s.cnt = '0;
          if (i_rc_clock_select) begin
            nxt_s.st = ST_DELAY;
          end else begin
            nxt_s.st    = ST_CONVERT;
            nxt_s.start = 1'b1;
          end
        end
      end
      ST_DELAY: begin
        nxt_s.cnt = s_ff.cnt + 4'h1;
        if (s_ff.cnt + 4'h1 >= TCY_CYC) begin
          nxt_s.st    = ST_CONVERT;
          nxt_s.start = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (core_push) begin
          nxt_s.st      = ST_IDLE;
          nxt_s.sampled = 1'b0;
          nxt_s.done    = 1'b1;
          if (i_cpu_sleep) begin
            nxt_s.wake   = i_int_enable;
            nxt_s.pwr_dn = !i_int_enable;
          end
        end
      end
      default: begin
        nxt_s.st = ST_OFF;
      end
    endcase
    // Done: set wins over clear
    if (i_done_clear && !(core_push)) begin
      nxt_s.done = 1'b0;
    end
    if (!i_cpu_sleep) begin
      nxt_s.pwr_dn = 1'b0;
    end
    // Halt aborts without resuming; registers untouched
    if (halt && s_ff.st != ST_OFF) begin
      nxt_s.st      = ST_IDLE;
      nxt_s.sampled = 1'b0;
      nxt_s.start   = 1'b0;
    end
    if (!i_converter_on) begin
      nxt_s.st      = ST_OFF;
      nxt_s.sampled = 1'b0;
      nxt_s.start   = 1'b0;
      nxt_s.pwr_dn  = 1'b0;
    end
    // Off mode gates both halves; power-down keeps converter_on
    nxt_s.power  = (nxt_s.st != ST_OFF) && !nxt_s.pwr_dn;
    nxt_s.clk_en = nxt_s.power && !halt;
    nxt_s.sample = (nxt_s.st == ST_SAMPLE);
    // Mux joins only analog-configured pins, direction ignored
    nxt_s.mux    = nxt_s.sample && i_analog_pin_config[i_channel_select];
    // Output stage formats on load
    if (fifo_rd_ready) begin
      nxt_s.rdv = fifo_rd_valid;
      if (fifo_rd_valid) begin
        nxt_s.rdd = fmt(i_output_format_select, fifo_rd_data);
      end
    end
  end

  // Reset clears control and aborts everything
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_ff    <= '0;
      s_ff.st <= ST_OFF;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_wr_ack      = s_ff.wr_ack;
  assign o_rd_valid    = s_ff.rdv;
  assign o_rd_data     = s_ff.rdd;
  assign o_done        = s_ff.done;
  assign o_wake        = s_ff.wake;
  assign o_core_power  = s_ff.power;
  assign o_core_clk_en = s_ff.clk_en;
  assign o_core_sample = s_ff.sample;
  assign o_core_start  = s_ff.start;
  assign o_discharge   = s_ff.discharge;
  assign o_mux_connect = s_ff.mux;
  assign o_port_read   = s_ff.port;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_sleep_conv;
    (s_ff.st == ST_CONVERT) && i_cpu_sleep && !i_rc_clock_select;
  endsequence

  property p_off_mode;
    !i_converter_on |=> (s_ff.st == ST_OFF) && !o_core_power && !o_core_clk_en;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("module not off");

  property p_off_gated;
    (s_ff.st == ST_OFF) |-> !o_core_sample && !o_mux_connect;
  endproperty
  a_off_gated: assert property (p_off_gated) else $error("off mode active");

  property p_sleep_abort;
    s_sleep_conv |=> (s_ff.st == ST_IDLE) && !o_core_start;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort");

  property p_rc_delay;
    (s_ff.st == ST_SAMPLE) && begin_conv && i_rc_clock_select && i_converter_on && !halt
      |=> !o_core_start ##1 o_core_start;
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("rc start delay");

  property p_done_set;
    core_push |=> o_done;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set");

  property p_sleep_pwrdn;
    core_push && i_cpu_sleep && !i_int_enable ##1 i_cpu_sleep && i_converter_on
      |=> !o_core_power;
  endproperty
  a_sleep_pwrdn: assert property (p_sleep_pwrdn) else $error("no power down");

  property p_idle_stop;
    i_cpu_idle && i_stop_in_idle && i_converter_on |=> !o_core_sample && !o_core_clk_en;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("idle not stopped");

  property p_port_zero;
    ##2 1'b1 |-> (o_port_read & $past(i_analog_pin_config)) == '0;
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("analog pin reads one");

  property p_mux_digital;
    o_mux_connect |-> $past(i_analog_pin_config[i_channel_select]);
  endproperty
  a_mux_digital: assert property (p_mux_digital) else $error("digital pin joined");

  property p_sample_min;
    o_core_start |-> $past(s_ff.sampled) || $past(s_ff.st == ST_DELAY);
  endproperty
  a_sample_min: assert property (p_sample_min) else $error("start before sample");
endmodule

`default_nettype wire

// ### core/acs_fifo.sv
/*
  Result buffer FIFO with valid/ready on both sides.
  Assumes a single clock; storage is not reset so contents survive reset.
*/
`timescale 1ns/1ps
`default_nettype none

module acs_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic      [WIDTH-1:0] o_rd_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } acs_fifo_st_t;

  acs_fifo_st_t s_ff;
  acs_fifo_st_t nxt_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;

  assign full       = (s_ff.wp[AW] != s_ff.rp[AW]) && (s_ff.wp[AW-1:0] == s_ff.rp[AW-1:0]);
  assign empty      = (s_ff.wp == s_ff.rp);
  assign o_wr_ready = !full;
  assign o_rd_valid = !empty;
  assign o_rd_data  = mem[s_ff.rp[AW-1:0]];

  always_comb begin
    nxt_s = s_ff;
    if (i_wr_valid && !full) begin
      nxt_s.wp = s_ff.wp + 1'b1;
    end
    if (i_rd_ready && !empty) begin
      nxt_s.rp = s_ff.rp + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Storage kept across reset
  always_ff @(posedge i_clk) begin
    if (i_wr_valid && !full) begin
      mem[s_ff.wp[AW-1:0]] <= i_wr_data;
    end
  end
endmodule

`default_nettype wire

// ### core/acs_pkg.sv
/*
  Constants, state codes and format codes for the converter control block
  and its result buffer FIFO.
  Assumes one 40 MHz clock and an asynchronous active-low device reset.
*/
`default_nettype none

package acs_pkg;
  localparam int unsigned CLK_NS     = 25;
  localparam int unsigned TAD_NS     = 100;
  localparam int unsigned TCY_NS     = 25;
  localparam int unsigned TAD_CYC_I  = (TAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TCY_CYC_I  = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  TAD_CYC    = 4'(TAD_CYC_I);
  localparam logic [3:0]  TCY_CYC    = 4'(TCY_CYC_I);
  localparam int unsigned RES_W      = 10;
  localparam int unsigned BUS_W      = 16;
  localparam int unsigned PINS       = 16;
  localparam int unsigned BUF_DEPTH  = 16;
  localparam int unsigned FRAC_SHIFT = 6;

  localparam logic [1:0] FMT_INT  = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_FRAC = 2'h2;
  localparam logic [1:0] FMT_SFRC = 2'h3;

  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_IDLE    = 5'h02,
    ST_SAMPLE  = 5'h04,
    ST_DELAY   = 5'h08,
    ST_CONVERT = 5'h10
  } acs_state_t;
endpackage

`default_nettype wire

// ### sim/acs_core_model.sv
/*
  Behavioural converter core: answers each start pulse with a done pulse
  and a result after a fixed count, or with nothing if i_clk_en falls while busy.
  Assumes starts come from the control block.
*/
`timescale 1ns/1ps
`default_nettype none

module acs_core_model #(
  parameter int unsigned CONV_CYC = 12
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_start,
  input  wire logic       i_clk_en,
  input  wire logic [9:0] i_value,
  output logic            o_done,
  output logic      [9:0] o_result
);
  int   cnt;
  logic busy;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt      <= 0;
      busy     <= 1'b0;
      o_done   <= 1'b0;
      o_result <= 10'h000;
    end else begin
      o_done   <= 1'b0;
      o_result <= ~o_result;
      if (i_start) begin
        busy <= 1'b1;
        cnt  <= 0;
      end else if (busy && !i_clk_en) begin
        busy <= 1'b0;
      end else if (busy && cnt == CONV_CYC - 1) begin
        busy     <= 1'b0;
        o_done   <= 1'b1;
        o_result <= i_value;
      end else if (busy) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

`default_nettype wire

// ### sim/tb_adc_sequencing_power_and_format.sv
/*
  Self-checking bench for the converter control block.
  Assumes the core model as partner and inputs driven on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_adc_sequencing_power_and_format;
  import acs_pkg::*;
  logic        i_clk, i_reset_n, i_converter_on, i_sample_control_bit, i_auto_sample, i_trigger;
  logic        i_rc_clock_select, i_stop_in_idle, i_cpu_sleep, i_cpu_idle, i_int_enable, i_done_clear;
  logic        i_core_done, i_wr_valid, i_rd_ready;
  logic        o_wr_ack, o_rd_valid, o_done, o_wake, o_core_power, o_core_clk_en;
  logic        o_core_sample, o_core_start, o_discharge, o_mux_connect;
  logic [1:0]  i_output_format_select;
  logic [3:0]  i_channel_select;
  logic [15:0] i_analog_pin_config, i_pin_level, i_wr_data, o_rd_data, o_port_read;
  logic [9:0]  i_core_result, value;
  int          miscompares, checked, starts, wakes, dis, l0, l1;
  logic [15:0] fx [4] = '{16'h02A5, 16'hFEA5, 16'hA940, 16'hA940};

  acs_ctrl dut (.i_clk, .i_reset_n, .i_converter_on, .i_sample_control_bit, .i_auto_sample, .i_trigger,
    .i_rc_clock_select, .i_stop_in_idle, .i_cpu_sleep, .i_cpu_idle, .i_int_enable, .i_done_clear,
    .i_output_format_select, .i_channel_select, .i_analog_pin_config, .i_pin_level, .i_core_done,
    .i_core_result, .i_wr_valid, .i_wr_data, .i_rd_ready, .o_wr_ack, .o_rd_valid, .o_rd_data, .o_done,
    .o_wake, .o_core_power, .o_core_clk_en, .o_core_sample, .o_core_start, .o_discharge,
    .o_mux_connect, .o_port_read);
  acs_core_model #(.CONV_CYC(12)) core (.i_clk, .i_reset_n, .i_start(o_core_start),
    .i_clk_en(o_core_clk_en), .i_value(value), .o_done(i_core_done), .o_result(i_core_result));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (o_core_start === 1'b1) starts++;
    if (o_wake === 1'b1) wakes++;
    if (o_discharge === 1'b1) dis++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Sample, then start by falling bit or trigger; returns cycles to start
  task automatic conv(input logic am, input logic [9:0] v, output int lat);
    lat = 0;
    value = v;
    tick(1);
    if (am) i_auto_sample = 1'b1;
    else i_sample_control_bit = 1'b1;
    tick(3);
    check(16'(o_mux_connect), 16'(i_analog_pin_config[i_channel_select]));
    check(16'(o_core_sample), 16'h0001);
    tick(3);
    if (am) i_trigger = 1'b1;
    else i_sample_control_bit = 1'b0;
    while (o_core_start !== 1'b1 && lat < 12) begin
      tick(1);
      lat++;
    end
    check(16'(o_core_sample), 16'h0000);
    i_trigger = 1'b0;
    i_auto_sample = 1'b0;
  endtask

  task automatic rd(input logic [15:0] exp);
    int n;
    n = 0;
    while (o_rd_valid !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    check(o_rd_data, exp);
    i_rd_ready = 1'b1;
    tick(1);
    i_rd_ready = 1'b0;
  endtask

  task automatic finish(input logic [15:0] exp);
    int n;
    n = 0;
    while (o_done !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    check(16'(o_done), 16'h0001);
    rd(exp);
    i_done_clear = 1'b1;
    tick(1);
    i_done_clear = 1'b0;
  endtask

  task automatic wr(input logic [15:0] d, output logic got);
    tick(1);
    i_wr_valid = 1'b1;
    i_wr_data = d;
    tick(1);
    i_wr_valid = 1'b0;
    got = o_wr_ack;
    tick(1);
    got = got | o_wr_ack;
  endtask

  task automatic s_power;
    int s;
    s = starts;
    tick(2);
    check(16'({o_core_power, o_core_clk_en}), 16'h0000);
    i_sample_control_bit = 1'b1;
    tick(8);
    i_sample_control_bit = 1'b0;
    tick(8);
    check(16'(starts - s), 16'h0000);
    i_converter_on = 1'b1;
    tick(2);
    check(16'({o_core_power, o_core_clk_en}), 16'h0003);
    tick(10);
  endtask

  task automatic s_formats;
    for (int i = 0; i < 4; i++) begin
      i_output_format_select = 2'(i);
      conv(1'b0, 10'h2A5, l0);
      finish(fx[i]);
    end
    i_output_format_select = FMT_SINT;
    conv(1'b0, 10'h155, l0);
    finish(16'h0155);
    i_output_format_select = FMT_INT;
  endtask

  task automatic s_manual_auto;
    int s, d;
    i_sample_control_bit = 1'b1;
    tick(2);
    i_sample_control_bit = 1'b0;
    s = starts;
    tick(12);
    check(16'(starts - s), 16'h0000);
    i_channel_select = 4'h9;
    d = dis;
    conv(1'b1, 10'h0C3, l1);
    check(16'(dis - d), 16'h0001);
    finish(16'h00C3);
    i_channel_select = 4'h3;
  endtask

  task automatic s_rc_sleep(input logic ie);
    int w;
    w = wakes;
    i_rc_clock_select = 1'b1;
    i_int_enable = ie;
    conv(1'b0, 10'h1F0, l1);
    i_cpu_sleep = 1'b1;
    check(16'(l1), 16'(l0) + 16'(TCY_CYC));
    finish(16'h01F0);
    check(16'(wakes - w), 16'(ie));
    check(16'(o_core_power), 16'(ie));
    i_cpu_sleep = 1'b0;
    i_rc_clock_select = 1'b0;
    tick(3);
    check(16'(o_core_power), 16'h0001);
  endtask

  task automatic s_abort;
    conv(1'b0, 10'h3FF, l1);
    i_cpu_sleep = 1'b1;
    tick(2);
    check(16'(o_core_clk_en), 16'h0000);
    tick(30);
    i_cpu_sleep = 1'b0;
    tick(30);
    check(16'({o_done, o_rd_valid}), 16'h0000);
    check(16'(o_core_power), 16'h0001);
  endtask

  task automatic s_idle(input logic sidl);
    i_stop_in_idle = sidl;
    conv(1'b0, 10'h2C1, l1);
    i_cpu_idle = 1'b1;
    tick(30);
    check(16'(o_done), 16'(!sidl));
    i_cpu_idle = 1'b0;
    if (!sidl) finish(16'h02C1);
    i_stop_in_idle = 1'b0;
  endtask

  task automatic s_reset;
    conv(1'b0, 10'h0AA, l1);
    i_reset_n = 1'b0;
    tick(1);
    check(16'({o_core_power, o_core_clk_en, o_done}), 16'h0000);
    i_reset_n = 1'b1;
    tick(30);
    check(16'({o_done, o_rd_valid}), 16'h0000);
  endtask

  task automatic s_port_buffer;
    int   acc;
    logic got;
    acc = 0;
    i_pin_level = 16'hA5A5;
    tick(4);
    check(o_port_read, 16'hA500);
    for (int i = 0; i < 20; i++) begin
      wr(16'hFC00 | 16'(i), got);
      if (got !== 1'b1) break;
      acc++;
    end
    check(16'(acc >= 16 && acc < 20), 16'h0001);
    for (int i = 0; i < acc; i++) rd(16'(i));
    tick(3);
    check(16'(o_rd_valid), 16'h0000);
  endtask

  initial begin
    {i_converter_on, i_sample_control_bit, i_auto_sample, i_trigger, i_rc_clock_select} = '0;
    {i_stop_in_idle, i_cpu_sleep, i_cpu_idle, i_int_enable, i_done_clear, i_wr_valid, i_rd_ready} = '0;
    i_reset_n = 1'b0;
    i_output_format_select = FMT_INT;
    i_channel_select = 4'h3;
    i_analog_pin_config = 16'h00FF;
    i_pin_level = 16'h0000;
    i_wr_data = 16'h0000;
    value = 10'h000;
    tick(20);
    i_reset_n = 1'b1;
    s_power();
    s_formats();
    s_manual_auto();
    s_rc_sleep(1'b1);
    s_rc_sleep(1'b0);
    s_abort();
    s_idle(1'b0);
    s_idle(1'b1);
    s_reset();
    s_port_buffer();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
